/* File: tefs_apb_slave.sv */
`timescale 1ns/1ps
`include "tefs_regs.svh"
// apb slave: one wait state, read data and answer from flops
module tefs_apb_slave
	import tefs_pkg::*;
(
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic [11:0] paddr,
	input wire logic [31:0] rd_value,
	input wire logic addr_hit,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic xfer_fire
);
	logic pready_q, pready_d;
	logic pslverr_q, pslverr_d;
	logic [31:0] prdata_q, prdata_d;
	logic access;

	// ==========================================================
	// access phase handling
	assign access = psel & penable;
	assign xfer_fire = access & pready_q; // completing edge
	always_comb
	begin
		pready_d = access & ~pready_q;
		pslverr_d = 1'b0;
		prdata_d = 32'h00000000;
		if (access & ~pready_q)
		begin
			pslverr_d = ~addr_hit; // unmapped address
			prdata_d = addr_hit ? rd_value : 32'h00000000;
		end
	end

	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
		begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= 32'h00000000;
		end
		else
		begin
			pready_q <= pready_d;
			pslverr_q <= pslverr_d;
			prdata_q <= prdata_d;
		end
	end

	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign prdata = prdata_q;
endmodule

/* File: tefs_chan_flags.sv */
`timescale 1ns/1ps
// one channel: match/capture flag and over-capture flag
module tefs_chan_flags (
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic match_hit,
	input wire logic capture_hit,
	input wire logic sw_gen,
	input wire logic is_input,
	input wire logic clr_cc,
	input wire logic clr_oc,
	input wire logic ccr_read,
	output logic cc_flag,
	output logic oc_flag,
	output logic cap_load,
	output logic cc_set_evt,
	output logic oc_set_evt
);
	logic cc_q, cc_d, oc_q, oc_d;
	logic pend_q, pend_d, load_q, load_d;
	logic cap_event;

	// ==========================================================
	// flag next state, set wins over any clear
	always_comb
	begin
		pend_d = sw_gen & is_input; // capture first, flag next cycle [R9]
		load_d = sw_gen & is_input; // [R9]
		cap_event = capture_hit | pend_q;
		cc_set_evt = match_hit | cap_event | (sw_gen & ~is_input); // [R6] [R7] [R9]
		oc_set_evt = cap_event & cc_q; // [R4]
		cc_d = cc_set_evt | (cc_q & ~clr_cc & ~(ccr_read & is_input)); // [R7] [R10]
		oc_d = oc_set_evt | (oc_q & ~clr_oc); // [R5] [R10]
	end

	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
		begin
			cc_q <= 1'b0;
			oc_q <= 1'b0;
			pend_q <= 1'b0;
			load_q <= 1'b0;
		end
		else
		begin
			cc_q <= cc_d;
			oc_q <= oc_d;
			pend_q <= pend_d;
			load_q <= load_d;
		end
	end

	assign cc_flag = cc_q;
	assign oc_flag = oc_q;
	assign cap_load = load_q;
endmodule

/* File: tefs_pkg.sv */
package tefs_pkg;
	// counter and compare values
	typedef logic [15:0] tefs_cnt_t;
	// flag layout: [10] trigger, [8] update, [7:4] over-capture, [3:0] match/capture
	typedef logic [10:0] tefs_flags_t;
endpackage

/* File: tefs_regs.svh */
`ifndef TEFS_REGS_SVH
`define TEFS_REGS_SVH
// ==========================================================
// register offsets
`define TEFS_OFS_EVENT_GEN 12'h078
`define TEFS_OFS_FLAG_STATUS 12'h07c
`define TEFS_OFS_CHAN_CONFIG 12'h0a0
`define TEFS_OFS_IRQ_STATUS 12'h0a4
`define TEFS_OFS_IRQ_MASK 12'h0a8
// ==========================================================
// field positions
`define TEFS_BIT_TRIGGER 10
`define TEFS_BIT_UPDATE 8
`define TEFS_BIT_OVERCAP0 4
`define TEFS_BIT_MATCHCAP0 0
`define TEFS_BIT_CENTER 8
// ==========================================================
// reset values and masks
`define TEFS_RST_FLAGS 11'h000
`define TEFS_RST_CONFIG 9'h000
`define TEFS_FLAG_MASK 11'h5ff
`endif

/* File: tefs_testbench.sv */
`timescale 1ns/1ps
`include "tefs_regs.svh"
// ==========================================================
// bench for the timer event flags
module testbench;
	import tefs_pkg::*;
	logic clk_sys = 1'b0;
	logic resetn = 1'b0;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata;
	logic pready, pslverr, cnt_tick = 1'b0, irq, center_aligned;
	tefs_cnt_t counter_value = 16'h0000;
	tefs_cnt_t cmp0 = 16'h0001, cmp1 = 16'h0005, cmp2 = 16'h0009, cmp3 = 16'h0fff;
	logic overflow_pulse = 1'b0, restart_trigger_pulse = 1'b0, trigger_pulse = 1'b0;
	logic [3:0] chan_capture_pulse = 4'h0, ccr_read_pulse = 4'h0;
	logic [3:0] chan_capture_load, chan_input_mode;
	logic update_gen_pulse, trigger_gen_pulse;
	int err_total = 0;
	int checks_done = 0;
	logic [31:0] r;
	logic e;
	logic [5:0] seen;
	tefs_top i_dut (.clk_sys(clk_sys), .resetn(resetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .counter_value(counter_value), .cnt_tick(cnt_tick),
		.chan0_compare_value(cmp0), .chan1_compare_value(cmp1), .chan2_compare_value(cmp2),
		.chan3_compare_value(cmp3), .overflow_pulse(overflow_pulse),
		.restart_trigger_pulse(restart_trigger_pulse), .trigger_pulse(trigger_pulse),
		.chan_capture_pulse(chan_capture_pulse), .ccr_read_pulse(ccr_read_pulse),
		.chan_capture_load(chan_capture_load), .update_gen_pulse(update_gen_pulse),
		.trigger_gen_pulse(trigger_gen_pulse), .chan_input_mode(chan_input_mode),
		.center_aligned(center_aligned), .irq(irq));
	// 25 MHz clock
	always #20 clk_sys = ~clk_sys;
	// ==========================================================
	// helpers
	task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
		checks_done++;
		if (got !== ex)
		begin
			$display("unexpected %s expected %h seen %h", nm, ex, got);
			err_total++;
		end
	endtask
	// apb transfer, held until pready is sampled high
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		// pready is a flop: its level at a falling edge is what the next rising edge takes
		@(negedge clk_sys);
		while (pready !== 1'b1)
			@(negedge clk_sys);
		r = prdata;
		e = pslverr;
		@(posedge clk_sys);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rf(input logic [31:0] ex);
		apb(1'b0, `TEFS_OFS_FLAG_STATUS, 32'h0);
		chk("flag_status", ex, r);
	endtask
	// event-gen write, gathering the generated pulses
	task automatic gen(input logic [31:0] d);
		apb(1'b1, `TEFS_OFS_EVENT_GEN, d);
		seen = 6'h00;
		repeat (6)
		begin
			@(negedge clk_sys);
			seen = seen | {trigger_gen_pulse, update_gen_pulse, chan_capture_load};
		end
	endtask
	task automatic tick(input logic [2:0] which, input logic [3:0] cap, input logic [3:0] rd);
		@(posedge clk_sys);
		{trigger_pulse, overflow_pulse, restart_trigger_pulse} <= which;
		chan_capture_pulse <= cap;
		ccr_read_pulse <= rd;
		@(posedge clk_sys);
		{trigger_pulse, overflow_pulse, restart_trigger_pulse} <= 3'b000;
		chan_capture_pulse <= 4'h0;
		ccr_read_pulse <= 4'h0;
	endtask
	// ==========================================================
	// scenarios
	task automatic t_reset();
		rf(32'h0);
		apb(1'b0, 12'h0fc, 32'h0);
		chk("unmapped_err", 32'h1, {31'h0, e});
		$display("reset test done");
	endtask
	task automatic t_trigger();
		tick(3'b100, 4'h0, 4'h0);
		rf(32'h400);
		apb(1'b1, `TEFS_OFS_FLAG_STATUS, 32'hffffffff);
		rf(32'h400);
		apb(1'b1, `TEFS_OFS_FLAG_STATUS, 32'h0);
		rf(32'h0);
		gen(32'h400);
		chk("gen_pulses", 32'h20, {26'h0, seen});
		rf(32'h400);
		// trigger held across the clearing write: the set must win
		trigger_pulse <= 1'b1;
		apb(1'b1, `TEFS_OFS_FLAG_STATUS, 32'h0);
		trigger_pulse <= 1'b0;
		rf(32'h400);
		apb(1'b1, `TEFS_OFS_FLAG_STATUS, 32'h0);
		$display("trigger test done");
	endtask
	task automatic t_update();
		for (int k = 0; k < 3; k++)
		begin
			if (k == 2)
			begin
				gen(32'h100);
				chk("upd_gen", 32'h10, {26'h0, seen});
			end
			else
				tick(k == 0 ? 3'b010 : 3'b001, 4'h0, 4'h0);
			rf(32'h100);
			apb(1'b1, `TEFS_OFS_FLAG_STATUS, 32'hffffffff);
			rf(32'h100);
			apb(1'b1, `TEFS_OFS_FLAG_STATUS, 32'hfffffeff);
			rf(32'h0);
		end
		$display("update test done");
	endtask
	task automatic t_match();
		apb(1'b1, `TEFS_OFS_CHAN_CONFIG, 32'h0);
		counter_value <= 16'h0005;
		@(posedge clk_sys);
		cnt_tick <= 1'b1;
		@(posedge clk_sys);
		cnt_tick <= 1'b0;
		rf(32'h002);
		apb(1'b1, `TEFS_OFS_FLAG_STATUS, 32'h0);
		apb(1'b1, `TEFS_OFS_CHAN_CONFIG, 32'h100);
		cnt_tick <= 1'b1;
		@(posedge clk_sys);
		cnt_tick <= 1'b0;
		rf(32'h0);
		chk("center", 32'h1, {31'h0, center_aligned});
		$display("match test done");
	endtask
	task automatic t_capture();
		apb(1'b1, `TEFS_OFS_CHAN_CONFIG, 32'h004);
		@(negedge clk_sys);
		chk("input_mode", 32'h4, {28'h0, chan_input_mode});
		tick(3'b000, 4'b0101, 4'h0);
		rf(32'h004);
		tick(3'b000, 4'b0100, 4'h0);
		rf(32'h044);
		tick(3'b000, 4'h0, 4'b0100);
		rf(32'h040);
		apb(1'b1, `TEFS_OFS_FLAG_STATUS, 32'hffffffbf);
		rf(32'h0);
		$display("capture test done");
	endtask
	task automatic t_swgen();
		apb(1'b1, `TEFS_OFS_CHAN_CONFIG, 32'h001);
		gen(32'h001);
		chk("cap_load", 32'h01, {26'h0, seen});
		rf(32'h001);
		apb(1'b1, `TEFS_OFS_CHAN_CONFIG, 32'h0);
		gen(32'h008);
		chk("cap_load_out", 32'h00, {26'h0, seen});
		rf(32'h009);
		apb(1'b1, `TEFS_OFS_FLAG_STATUS, 32'h0);
		$display("software generation test done");
	endtask
	task automatic t_irq();
		// every event so far left its sticky bit; this read clears them
		apb(1'b0, `TEFS_OFS_IRQ_STATUS, 32'h0);
		chk("irq_status_all", 32'h54f, r);
		apb(1'b1, `TEFS_OFS_IRQ_MASK, 32'h100);
		tick(3'b010, 4'h0, 4'h0);
		repeat (3) @(posedge clk_sys);
		chk("irq_set", 32'h1, {31'h0, irq});
		apb(1'b0, `TEFS_OFS_IRQ_STATUS, 32'h0);
		chk("irq_status", 32'h100, r);
		repeat (3) @(posedge clk_sys);
		chk("irq_clear", 32'h0, {31'h0, irq});
		apb(1'b1, `TEFS_OFS_IRQ_MASK, 32'h0);
		tick(3'b010, 4'h0, 4'h0);
		repeat (3) @(posedge clk_sys);
		chk("irq_masked", 32'h0, {31'h0, irq});
		apb(1'b1, `TEFS_OFS_FLAG_STATUS, 32'h0);
		$display("interrupt test done");
	endtask
	// ==========================================================
	// verdict and run control
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	initial
	begin
		repeat (4) @(posedge clk_sys);
		resetn <= 1'b1;
		t_reset();
		t_trigger();
		t_update();
		t_match();
		t_capture();
		t_swgen();
		t_irq();
		tally_and_finish();
	end
	// watchdog well beyond the expected run length
	initial
	begin
		repeat (5000) @(posedge clk_sys);
		err_total++;
		tally_and_finish();
	end
endmodule

/* File: tefs_top.sv */
`timescale 1ns/1ps
`include "tefs_regs.svh"
// How it works
// [R1] trigger event sets sticky trigger flag
// [R2] update event sets flag, held until cleared
// [R3] update from overflow, generation bit, restart
// [R4] capture while flag set sets over-capture
// [R5] software writes zero to clear flags
// [R6] output match sets flag, not center-aligned
// [R7] input capture sets; write-zero or read clears
// [R8] trigger generation bit sets flag, self-clears
// [R9] input generation: load capture, then flag
// [R10] write one ignored, reserved zero, set wins
module tefs_top
	import tefs_pkg::*;
(
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire tefs_pkg::tefs_cnt_t counter_value,
	input wire logic cnt_tick,
	input wire tefs_pkg::tefs_cnt_t chan0_compare_value,
	input wire tefs_pkg::tefs_cnt_t chan1_compare_value,
	input wire tefs_pkg::tefs_cnt_t chan2_compare_value,
	input wire tefs_pkg::tefs_cnt_t chan3_compare_value,
	input wire logic overflow_pulse,
	input wire logic restart_trigger_pulse,
	input wire logic trigger_pulse,
	input wire logic [3:0] chan_capture_pulse,
	input wire logic [3:0] ccr_read_pulse,
	output logic [3:0] chan_capture_load,
	output logic update_gen_pulse,
	output logic trigger_gen_pulse,
	output logic [3:0] chan_input_mode,
	output logic center_aligned,
	output logic irq
);
	import tefs_pkg::*;

	logic xfer_fire, wr_fire, rd_fire, addr_hit;
	logic [31:0] rd_value;
	tefs_flags_t flags, set_evt, clr_w0;
	tefs_flags_t irq_status_q, irq_status_d, irq_mask_q, irq_mask_d;
	logic [8:0] config_q, config_d;
	logic tgen_q, tgen_d, ugen_q, ugen_d;
	logic [3:0] ccg_q, ccg_d;
	logic trig_flag_q, trig_flag_d, upd_flag_q, upd_flag_d;
	logic irq_q, irq_d;
	logic wr_evg, wr_status, rd_irq_status;
	tefs_cnt_t cmp_value [4];
	logic [3:0] cc_flag, oc_flag, cc_set, oc_set;

	// ==========================================================
	// bus slave and decode
	tefs_apb_slave u_apb (
		.clk_sys(clk_sys),
		.resetn(resetn),
		.psel(psel),
		.penable(penable),
		.paddr(paddr),
		.rd_value(rd_value),
		.addr_hit(addr_hit),
		.prdata(prdata),
		.pready(pready),
		.pslverr(pslverr),
		.xfer_fire(xfer_fire)
	);

	// strobes at the completing edge only
	assign wr_fire = xfer_fire & pwrite;
	assign rd_fire = xfer_fire & ~pwrite;
	assign wr_evg = wr_fire & (paddr == `TEFS_OFS_EVENT_GEN);
	assign wr_status = wr_fire & (paddr == `TEFS_OFS_FLAG_STATUS);
	assign rd_irq_status = rd_fire & (paddr == `TEFS_OFS_IRQ_STATUS);

	// read mux, reserved bits zero
	always_comb
	begin
		addr_hit = 1'b1;
		rd_value = 32'h00000000;
		unique case (paddr)
			`TEFS_OFS_EVENT_GEN: rd_value = 32'h00000000;
			`TEFS_OFS_FLAG_STATUS: rd_value = {21'h000000, flags & `TEFS_FLAG_MASK}; // [R10]
			`TEFS_OFS_CHAN_CONFIG: rd_value = {23'h000000, config_q};
			`TEFS_OFS_IRQ_STATUS: rd_value = {21'h000000, irq_status_q};
			`TEFS_OFS_IRQ_MASK: rd_value = {21'h000000, irq_mask_q};
			default: addr_hit = 1'b0;
		endcase
	end

	// ==========================================================
	// configuration and self-clearing generation bits
	always_comb
	begin
		config_d = config_q;
		if (wr_fire && paddr == `TEFS_OFS_CHAN_CONFIG)
		begin
			config_d = {pwdata[`TEFS_BIT_CENTER], 4'h0, pwdata[3:0]};
		end
		tgen_d = wr_evg & pwdata[`TEFS_BIT_TRIGGER]; // one cycle, then clear [R8]
		ugen_d = wr_evg & pwdata[`TEFS_BIT_UPDATE];
		ccg_d = wr_evg ? pwdata[3:0] : 4'h0;
	end

	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
		begin
			config_q <= `TEFS_RST_CONFIG;
			tgen_q <= 1'b0;
			ugen_q <= 1'b0;
			ccg_q <= 4'h0;
		end
		else
		begin
			config_q <= config_d;
			tgen_q <= tgen_d;
			ugen_q <= ugen_d;
			ccg_q <= ccg_d;
		end
	end

	assign chan_input_mode = config_q[3:0];
	assign center_aligned = config_q[`TEFS_BIT_CENTER];
	assign trigger_gen_pulse = tgen_q;
	assign update_gen_pulse = ugen_q;

	// ==========================================================
	// write-zero clear vector; a one leaves the bit alone
	assign clr_w0 = wr_status ? ~pwdata[10:0] : 11'h000; // [R5] [R10]

	// ==========================================================
	// trigger and update flags
	always_comb
	begin
		trig_flag_d = trigger_pulse | tgen_q | (trig_flag_q & ~clr_w0[`TEFS_BIT_TRIGGER]); // [R1] [R8]
		upd_flag_d = overflow_pulse | restart_trigger_pulse | ugen_q
			| (upd_flag_q & ~clr_w0[`TEFS_BIT_UPDATE]); // [R2] [R3]
	end

	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
		begin
			trig_flag_q <= 1'b0;
			upd_flag_q <= 1'b0;
		end
		else
		begin
			trig_flag_q <= trig_flag_d;
			upd_flag_q <= upd_flag_d;
		end
	end

	// ==========================================================
	// per-channel flags
	assign cmp_value[0] = chan0_compare_value;
	assign cmp_value[1] = chan1_compare_value;
	assign cmp_value[2] = chan2_compare_value;
	assign cmp_value[3] = chan3_compare_value;

	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++)
		begin : g_chan
			tefs_chan_flags u_chan (
				.clk_sys(clk_sys),
				.resetn(resetn),
				.match_hit(~config_q[gi] & ~center_aligned & cnt_tick
					& (counter_value == cmp_value[gi])), // [R6]
				.capture_hit(config_q[gi] & chan_capture_pulse[gi]), // [R7]
				.sw_gen(ccg_q[gi]),
				.is_input(config_q[gi]),
				.clr_cc(clr_w0[`TEFS_BIT_MATCHCAP0 + gi]),
				.clr_oc(clr_w0[`TEFS_BIT_OVERCAP0 + gi]),
				.ccr_read(ccr_read_pulse[gi]),
				.cc_flag(cc_flag[gi]),
				.oc_flag(oc_flag[gi]),
				.cap_load(chan_capture_load[gi]),
				.cc_set_evt(cc_set[gi]),
				.oc_set_evt(oc_set[gi])
			);
		end
	endgenerate

	assign flags = {trig_flag_q, 1'b0, upd_flag_q, oc_flag, cc_flag};

	// ==========================================================
	// interrupt status (read clears, set wins), mask, output
	assign set_evt = {trigger_pulse | tgen_q, 1'b0,
		overflow_pulse | restart_trigger_pulse | ugen_q, oc_set, cc_set};

	always_comb
	begin
		irq_mask_d = irq_mask_q;
		if (wr_fire && paddr == `TEFS_OFS_IRQ_MASK)
		begin
			irq_mask_d = pwdata[10:0] & `TEFS_FLAG_MASK;
		end
		irq_status_d = set_evt | (rd_irq_status ? 11'h000 : irq_status_q);
		irq_d = |(irq_status_d & irq_mask_d);
	end

	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
		begin
			irq_status_q <= `TEFS_RST_FLAGS;
			irq_mask_q <= `TEFS_RST_FLAGS;
			irq_q <= 1'b0;
		end
		else
		begin
			irq_status_q <= irq_status_d;
			irq_mask_q <= irq_mask_d;
			irq_q <= irq_d;
		end
	end

	assign irq = irq_q;

	// ==========================================================
	// checks
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!resetn);

	sequence s_gen_write0;
		wr_evg && pwdata[0] && config_q[0];
	endsequence

	sequence s_load_then_flag0;
		!chan_capture_load[0] ##1 chan_capture_load[0] ##1 cc_flag[0];
	endsequence

	// event flag checks
	trig_flag_set_a: assert property (trigger_pulse |=> trig_flag_q) // [R1]
		else $error("trigger flag not set");
	trig_flag_hold_a: assert property (trig_flag_q && !clr_w0[10] |=> trig_flag_q) // [R1]
		else $error("trigger flag dropped without clear");
	upd_flag_hold_a: assert property (upd_flag_q && !clr_w0[8] |=> upd_flag_q) // [R2]
		else $error("update flag dropped without clear");
	upd_sources_a: assert property ((overflow_pulse || restart_trigger_pulse) // [R3]
		|=> upd_flag_q && irq_status_q[8])
		else $error("update source did not set flag");
	ugen_self_a: assert property (wr_evg && pwdata[8] // [R3]
		|=> update_gen_pulse ##1 (!update_gen_pulse && upd_flag_q))
		else $error("update generation misbehaved");
	w0c_clear_a: assert property (wr_status && !pwdata[0] && !cc_set[0] // [R5]
		|=> !cc_flag[0])
		else $error("write zero did not clear");
	tgen_self_a: assert property (wr_evg && pwdata[10] // [R8]
		|=> trigger_gen_pulse ##1 (!trigger_gen_pulse && trig_flag_q))
		else $error("trigger generation misbehaved");
	swgen_order_a: assert property (s_gen_write0 |-> ##1 s_load_then_flag0) // [R9]
		else $error("capture load and flag out of order");
	set_wins_a: assert property (trigger_pulse && wr_status && !pwdata[10] // [R10]
		|=> trig_flag_q)
		else $error("clear beat a set");
	one_ignored_a: assert property (wr_status && pwdata[8] && upd_flag_q // [R10]
		|=> upd_flag_q)
		else $error("write one changed a flag");

	// interrupt output follows pending and enabled status
	irq_level_a: assert property (|(irq_status_q & irq_mask_q) |-> irq)
		else $error("interrupt not raised");
	irq_low_a: assert property (!(|(irq_status_q & irq_mask_q)) |-> !irq)
		else $error("interrupt raised with nothing pending");

	// per-channel checks
	generate
		for (gi = 0; gi < 4; gi++)
		begin : g_chk
			overcap_set_a: assert property (chan_capture_pulse[gi] && config_q[gi] // [R4]
				&& cc_flag[gi] |=> oc_flag[gi])
				else $error("over-capture missed");
			overcap_hold_a: assert property (oc_flag[gi] // [R4]
				&& !clr_w0[`TEFS_BIT_OVERCAP0 + gi] |=> oc_flag[gi])
				else $error("over-capture flag dropped without clear");
			oc_clear_a: assert property (wr_status && !pwdata[`TEFS_BIT_OVERCAP0 + gi] // [R5]
				&& !oc_set[gi] |=> !oc_flag[gi])
				else $error("write zero did not clear over-capture");
			match_set_a: assert property (cnt_tick && !config_q[gi] && !center_aligned // [R6]
				&& counter_value == cmp_value[gi] |=> cc_flag[gi])
				else $error("compare match not flagged");
			center_block_a: assert property (center_aligned && !config_q[gi] // [R6]
				&& !cc_flag[gi] && !ccg_q[gi] |=> !cc_flag[gi])
				else $error("flag set in center-aligned mode");
			capture_set_a: assert property (chan_capture_pulse[gi] && config_q[gi] // [R7]
				|=> cc_flag[gi])
				else $error("capture not flagged");
			out_capture_a: assert property (chan_capture_pulse[gi] && !config_q[gi] // [R7]
				&& !cc_flag[gi] && !ccg_q[gi] && !cnt_tick |=> !cc_flag[gi])
				else $error("capture flagged on an output channel");
			read_clear_a: assert property (ccr_read_pulse[gi] && config_q[gi] // [R7]
				&& !cc_set[gi] |=> !cc_flag[gi])
				else $error("capture register read did not clear");
			load_once_a: assert property (chan_capture_load[gi] // [R9]
				|=> !chan_capture_load[gi])
				else $error("capture load longer than one cycle");
		end
	endgenerate
endmodule
